// >>> hw/flash_protect_pkg.sv
package flash_protect_pkg;
   localparam int          AW            = 32;
   localparam int          DW            = 32;
   // Register byte addresses
   localparam logic [31:0] ADDR_STATUS   = 32'hfffff800;
   localparam logic [31:0] ADDR_MODE     = 32'hfffff804;
   localparam logic [31:0] ADDR_COMMAND  = 32'hfffff808;
   localparam logic [31:0] ADDR_DATA     = 32'hfffff80c;
   localparam logic [31:0] ADDR_ADDRESS  = 32'hfffff810;
   localparam logic [31:0] ADDR_SIGN     = 32'hfffff818;
   localparam logic [31:0] ADDR_PROT_P   = 32'hfffff81c;
   localparam logic [31:0] ADDR_PROT_V   = 32'hfffff820;
   localparam logic [31:0] ADDR_REMAP    = 32'hffff0220;
   // Reset values
   localparam logic [15:0] RST_ADDRESS   = 16'h0000;
   localparam logic [15:0] RST_DATA      = 16'h0000;
   localparam logic [23:0] RST_SIGN      = 24'hffffff;
   localparam logic [31:0] RST_PROT_P    = 32'h00000000;
   localparam logic [31:0] RST_PROT_V    = 32'hffffffff;
   localparam logic [31:0] PROT_NONE     = 32'hffffffff;
   localparam logic [7:0]  RST_MODE      = 8'h00;
   // Fields
   localparam int          MODE_KEY_BIT  = 3;
   localparam int          READ_PROT_BIT = 31;
   localparam int          GROUP_LSB     = 11;
   localparam int          GROUP_W       = 5;
   localparam logic [4:0]  KERNEL_GROUP  = 5'h1f;
   localparam int          REMAP_BIT     = 0;
   // Mass erase key
   localparam logic [15:0] KEY_DATA      = 16'h3cff;
   localparam logic [15:0] KEY_ADDRESS   = 16'hffc3;
   // Commands
   localparam logic [7:0]  CMD_NULL      = 8'h00;
   localparam logic [7:0]  CMD_READ      = 8'h01;
   localparam logic [7:0]  CMD_WRITE     = 8'h02;
   localparam logic [7:0]  CMD_ERASE_WR  = 8'h03;
   localparam logic [7:0]  CMD_VERIFY    = 8'h04;
   localparam logic [7:0]  CMD_PAGE_ERA  = 8'h05;
   localparam logic [7:0]  CMD_MASS_ERA  = 8'h06;
   localparam logic [7:0]  CMD_DONE      = 8'h07;
   localparam logic [7:0]  CMD_SIGN      = 8'h0b;
   localparam logic [7:0]  CMD_PROTECT   = 8'h0c;
   // Timing
   localparam longint      CLK_HZ        = 10_000_000;
   localparam longint      ERASE_TIME_MS = 2480;
   localparam int          ERASE_CYCLES  =
      int'(ERASE_TIME_MS * CLK_HZ / 1000);
   localparam int          SIGN_CYCLES   = 32778;
   localparam int          KERNEL_CYCLES = 16;
   // Access kinds and cycle costs
   localparam logic [1:0]  ACC_FETCH     = 2'h0;
   localparam logic [1:0]  ACC_BRANCH    = 2'h1;
   localparam logic [1:0]  ACC_DATA      = 2'h2;
   localparam logic [7:0]  CYC_SRAM_FETCH  = 8'h01;
   localparam logic [7:0]  CYC_FL_FETCH32  = 8'h02;
   localparam logic [7:0]  CYC_FL_FETCH16  = 8'h01;
   localparam logic [7:0]  CYC_FL_DECODE   = 8'h01;
   localparam logic [7:0]  CYC_FL_REFILL   = 8'h04;
   localparam logic [7:0]  CYC_SRAM_REFILL = 8'h02;
   localparam logic [7:0]  CYC_SRAM_DATA   = 8'h01;
   localparam logic [7:0]  CYC_FL_DATA     = 8'h04;
   // Memory map
   localparam logic [31:0] MIRROR_TOP    = 32'h00000020;
   localparam logic [31:0] MIRROR_SIZE   = 32'h00040000;
   localparam logic [31:0] SRAM_BASE     = 32'h00040000;
   localparam logic [31:0] FLASH_BASE    = 32'h00080000;
   localparam logic [31:0] FLASH_SIZE    = 32'h00010000;
   localparam logic [31:0] RESET_VECTOR  = 32'h00000000;

   typedef enum logic [2:0] {
      ENG_IDLE  = 3'b001,
      ENG_ERASE = 3'b010,
      ENG_SIGN  = 3'b100
   } engine_e;
endpackage : flash_protect_pkg

// >>> hw/flash_protect_fetch_remap.sv
// Contract
// - 16-bit flash address register, resets zero
// - read-only 24-bit signature, resets all ones
// - persistent protection keyed, effective after reset
// - volatile protection acts at once, no key
// - any reset sets volatile protection all ones
// - bit 31 zero blocks code reading
// - bits 30-0 guard four-page groups from writes
// - key data, key address, key bit, then 0x06
// - SRAM fetch one cycle; data adds 1/3
// - flash fetch two cycles wide, one compressed
// - flash branch: one decode, four refill
// - flash data: decode, two access, one dead
// - data dead cycles scale with word count
// - vectors occupy the lowest addresses
// - every reset maps flash at bottom
// - remap bit 0 mirrors SRAM, reversible
// - hidden kernel runs, then jumps to zero
// - mass erase spares the kernel region
// - protect command runs once; only a keyed mass erase clears
// - signature takes fixed cycles, then loads
`timescale 1ns/1ps
module flash_protect_fetch_remap
   import flash_protect_pkg::*;
#(
   parameter int ERASE_CYC  = ERASE_CYCLES,
   parameter int SIGN_CYC   = SIGN_CYCLES,
   parameter int KERNEL_CYC = KERNEL_CYCLES
)(
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [AW-1:0] paddr,
   input  wire logic [DW-1:0] pwdata,
   output logic      [DW-1:0] prdata,
   output logic               pready,
   output logic               pslverr,
   input  wire logic          boot_mode_pin,
   input  wire logic [31:0]   prot_stored,
   input  wire logic [15:0]   flash_rdata,
   input  wire logic [23:0]   flash_sig_value,
   output logic               flash_op_pulse,
   output logic      [7:0]    flash_op_code,
   output logic      [15:0]   flash_op_addr,
   output logic      [15:0]   flash_op_data,
   output logic               prot_save_pulse,
   output logic      [31:0]   prot_save_value,
   output logic               kernel_active,
   output logic               core_start,
   output logic      [31:0]   core_start_pc,
   output logic               remap_sram,
   input  wire logic          acc_req,
   input  wire logic [1:0]    acc_kind,
   input  wire logic          acc_compact,
   input  wire logic [4:0]    acc_words,
   input  wire logic [31:0]   acc_addr,
   output logic               acc_busy,
   output logic               acc_done,
   output logic               acc_err,
   output logic      [7:0]    acc_cost
);

   function automatic logic in_flash(input logic [31:0] a,
                                     input logic        rm);
      logic low;
      low = a < MIRROR_SIZE;
      in_flash = (low && !rm) ||
                 (a >= FLASH_BASE && a < FLASH_BASE + FLASH_SIZE);
   endfunction : in_flash

   function automatic logic group_locked(input logic [15:0] a,
                                         input logic [31:0] p);
      logic [GROUP_W-1:0] g;
      g = a[GROUP_LSB +: GROUP_W];
      group_locked = (g == KERNEL_GROUP) || !p[g];
   endfunction : group_locked

   logic [15:0]   address_reg;
   logic [15:0]   data_reg;
   logic [23:0]   sign_reg;
   logic [31:0]   prot_p_reg;
   logic [31:0]   prot_p_live_reg;
   logic [31:0]   prot_v_reg;
   logic [7:0]    mode_reg;
   logic [7:0]    command_reg;
   logic          remap_reg;
   logic          protect_used_reg;
   logic          denied_reg;
   logic          verify_ok_reg;
   logic          boot_pend_reg;
   logic          boot_mode_reg;
   logic [7:0]    kernel_cnt_reg;
   engine_e       eng_reg;
   logic [31:0]   eng_cnt_reg;
   logic [7:0]    acc_cnt_reg;
   logic [31:0]   prot_eff;
   logic          key_ok;
   logic          wr_en;
   logic          setup;
   logic          mapped;
   logic [DW-1:0] rd_value;
   logic          cmd_go;
   logic [7:0]    cmd;
   logic [7:0]    cost_next;
   logic          cost_flash;

   assign setup  = psel && !penable;
   assign wr_en  = psel && penable && pready && pwrite;
   assign cmd    = pwdata[7:0];
   assign cmd_go = wr_en && paddr == ADDR_COMMAND &&
                   eng_reg == ENG_IDLE && !kernel_active;
   // Both layers combine; a zero in either protects
   assign prot_eff = prot_p_live_reg & prot_v_reg;
   assign key_ok = data_reg == KEY_DATA &&
                   address_reg == KEY_ADDRESS &&
                   mode_reg[MODE_KEY_BIT];

   always_comb
   begin
      mapped   = 1'b1;
      rd_value = '0;
      case (paddr)
         ADDR_STATUS:  rd_value = {28'h0, verify_ok_reg, denied_reg,
                                   protect_used_reg,
                                   eng_reg != ENG_IDLE};
         ADDR_MODE:    rd_value = {24'h0, mode_reg};
         ADDR_COMMAND: rd_value = {24'h0, command_reg};
         ADDR_DATA:    rd_value = {16'h0, data_reg};
         ADDR_ADDRESS: rd_value = {16'h0, address_reg};
         ADDR_SIGN:    rd_value = {8'h0, sign_reg};
         ADDR_PROT_P:  rd_value = prot_p_reg;
         ADDR_PROT_V:  rd_value = prot_v_reg;
         ADDR_REMAP:   rd_value = {31'h0, remap_reg};
         default:      mapped   = 1'b0;
      endcase
   end

   // One wait-free access phase; read data captured at setup
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end
      else if (setup)
      begin
         pready  <= 1'b1;
         pslverr <= !mapped;
         prdata  <= (pwrite || !mapped) ? '0 : rd_value;
      end
      else
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mode_reg  <= RST_MODE;
         remap_reg <= 1'b0;
      end
      else
      begin
         if (wr_en && paddr == ADDR_MODE)
            mode_reg <= pwdata[7:0];
         // Software must flip this from above the mirror
         if (wr_en && paddr == ADDR_REMAP)
            remap_reg <= pwdata[REMAP_BIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         remap_sram <= 1'b0;
      else
         remap_sram <= remap_reg;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         address_reg <= RST_ADDRESS;
      else if (wr_en && paddr == ADDR_ADDRESS)
         address_reg <= pwdata[15:0];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         data_reg <= RST_DATA;
      else if (wr_en && paddr == ADDR_DATA)
         data_reg <= pwdata[15:0];
      else if (cmd_go && cmd == CMD_READ && prot_eff[READ_PROT_BIT])
         data_reg <= flash_rdata;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prot_v_reg <= RST_PROT_V;
      else if (wr_en && paddr == ADDR_PROT_V)
         prot_v_reg <= pwdata;
   end

   // Persistent value reaches the live mask only after the protect command and the next reset
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prot_p_reg <= RST_PROT_P;
      else if (wr_en && paddr == ADDR_PROT_P && key_ok)
         prot_p_reg <= pwdata;
   end

   // Stored value is caught on the first edge after release
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         boot_pend_reg    <= 1'b1;
         boot_mode_reg    <= 1'b0;
         prot_p_live_reg  <= PROT_NONE;
         protect_used_reg <= 1'b0;
      end
      else if (boot_pend_reg)
      begin
         boot_pend_reg    <= 1'b0;
         boot_mode_reg    <= boot_mode_pin;
         prot_p_live_reg  <= prot_stored;
         protect_used_reg <= prot_stored != PROT_NONE;
      end
      else if (cmd_go && cmd == CMD_PROTECT)
         protect_used_reg <= 1'b1;
      else if (cmd_go && cmd == CMD_MASS_ERA && key_ok)
         protect_used_reg <= 1'b0;
   end

   // Kernel holds the core until done; low pin stays in kernel
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         kernel_active  <= 1'b1;
         kernel_cnt_reg <= '0;
         core_start     <= 1'b0;
         core_start_pc  <= RESET_VECTOR;
      end
      else
      begin
         core_start <= 1'b0;
         if (kernel_active && !boot_pend_reg && boot_mode_reg)
         begin
            if (kernel_cnt_reg == 8'(KERNEL_CYC - 1))
            begin
               kernel_active <= 1'b0;
               core_start    <= 1'b1;
               core_start_pc <= RESET_VECTOR;
            end
            else
               kernel_cnt_reg <= kernel_cnt_reg + 8'h01;
         end
      end
   end

   // Command engine
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         eng_reg         <= ENG_IDLE;
         eng_cnt_reg     <= '0;
         command_reg     <= CMD_NULL;
         sign_reg        <= RST_SIGN;
         denied_reg      <= 1'b0;
         verify_ok_reg   <= 1'b0;
         flash_op_pulse  <= 1'b0;
         flash_op_code   <= CMD_NULL;
         flash_op_addr   <= '0;
         flash_op_data   <= '0;
         prot_save_pulse <= 1'b0;
         prot_save_value <= PROT_NONE;
      end
      else
      begin
         flash_op_pulse  <= 1'b0;
         prot_save_pulse <= 1'b0;
         case (eng_reg)
            ENG_IDLE:
            begin
               if (cmd_go)
               begin
                  command_reg   <= cmd;
                  denied_reg    <= 1'b0;
                  flash_op_code <= cmd;
                  flash_op_addr <= address_reg;
                  flash_op_data <= data_reg;
                  case (cmd)
                     CMD_READ, CMD_VERIFY:
                     begin
                        command_reg <= CMD_DONE;
                        if (!prot_eff[READ_PROT_BIT])
                           denied_reg <= 1'b1;
                        else if (cmd == CMD_VERIFY)
                           verify_ok_reg <= flash_rdata == data_reg;
                     end
                     CMD_WRITE, CMD_ERASE_WR, CMD_PAGE_ERA:
                     begin
                        command_reg <= CMD_DONE;
                        if (group_locked(address_reg, prot_eff))
                           denied_reg <= 1'b1;
                        else
                           flash_op_pulse <= 1'b1;
                     end
                     CMD_MASS_ERA:
                     begin
                        if (key_ok)
                        begin
                           // Array erases user space only
                           flash_op_pulse <= 1'b1;
                           eng_cnt_reg    <= '0;
                           eng_reg        <= ENG_ERASE;
                        end
                        else
                        begin
                           command_reg <= CMD_NULL;
                           denied_reg  <= 1'b1;
                        end
                     end
                     CMD_SIGN:
                     begin
                        eng_cnt_reg <= '0;
                        eng_reg     <= ENG_SIGN;
                     end
                     CMD_PROTECT:
                     begin
                        if (protect_used_reg)
                           denied_reg <= 1'b1;
                        else
                        begin
                           prot_save_pulse <= 1'b1;
                           prot_save_value <= prot_p_reg;
                        end
                     end
                     default: ;
                  endcase
               end
            end
            ENG_ERASE:
            begin
               if (eng_cnt_reg == 32'(ERASE_CYC - 1))
               begin
                  prot_save_pulse <= 1'b1;
                  prot_save_value <= PROT_NONE;
                  command_reg     <= CMD_DONE;
                  eng_reg         <= ENG_IDLE;
               end
               else
                  eng_cnt_reg <= eng_cnt_reg + 32'h1;
            end
            ENG_SIGN:
            begin
               if (eng_cnt_reg == 32'(SIGN_CYC - 1))
               begin
                  sign_reg <= flash_sig_value;
                  eng_reg  <= ENG_IDLE;
               end
               else
                  eng_cnt_reg <= eng_cnt_reg + 32'h1;
            end
            default: eng_reg <= ENG_IDLE;
         endcase
      end
   end

   // Core access timing
   assign cost_flash = in_flash(acc_addr, remap_reg);

   always_comb
   begin
      cost_next = CYC_SRAM_FETCH;
      case (acc_kind)
         ACC_FETCH:
            if (cost_flash)
               cost_next = acc_compact ? CYC_FL_FETCH16
                                       : CYC_FL_FETCH32;
         ACC_BRANCH:
            if (cost_flash)
               cost_next = (acc_compact ? CYC_FL_FETCH16
                                        : CYC_FL_FETCH32) +
                           CYC_FL_DECODE + CYC_FL_REFILL;
            else
               cost_next = CYC_SRAM_FETCH + CYC_SRAM_REFILL;
         ACC_DATA:
            // Decode, two-cycle word, trailing dead cycle
            if (cost_flash)
               cost_next = 8'(CYC_FL_DATA * acc_words);
            else
               cost_next = 8'(CYC_SRAM_DATA * acc_words);
         default: cost_next = CYC_SRAM_FETCH;
      endcase
   end

   // Requests while busy are dropped; core must wait for done
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         acc_busy    <= 1'b0;
         acc_done    <= 1'b0;
         acc_err     <= 1'b0;
         acc_cost    <= '0;
         acc_cnt_reg <= '0;
      end
      else
      begin
         acc_done <= 1'b0;
         if (!acc_busy && acc_req && !kernel_active)
         begin
            acc_busy    <= 1'b1;
            acc_cost    <= cost_next;
            acc_cnt_reg <= cost_next;
            acc_err     <= acc_kind == ACC_DATA && cost_flash &&
                           !prot_eff[READ_PROT_BIT];
         end
         else if (acc_busy)
         begin
            if (acc_cnt_reg <= 8'h01)
            begin
               acc_busy <= 1'b0;
               acc_done <= 1'b1;
            end
            acc_cnt_reg <= acc_cnt_reg - 8'h01;
         end
      end
   end

endmodule : flash_protect_fetch_remap

// >>> verif/flash_protect_asserts.sv
`timescale 1ns/1ps
module flash_protect_asserts
   import flash_protect_pkg::*;
#(
   parameter int KERNEL_CYC = 4
)(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        remap_sram,
   input wire logic        boot_mode_pin,
   input wire logic        kernel_active,
   input wire logic        core_start,
   input wire logic [31:0] core_start_pc,
   input wire logic        flash_op_pulse,
   input wire logic [7:0]  flash_op_code,
   input wire logic [15:0] flash_op_addr,
   input wire logic        acc_req,
   input wire logic [1:0]  acc_kind,
   input wire logic        acc_compact,
   input wire logic [4:0]  acc_words,
   input wire logic [31:0] acc_addr,
   input wire logic        acc_busy,
   input wire logic        acc_done,
   input wire logic [7:0]  acc_cost
);
   localparam int K1 = KERNEL_CYC + 1;
   logic take;
   logic in_fl;
   logic in_sr;
   logic wr_acc;
   assign take = acc_req && !acc_busy && !kernel_active;
   assign in_fl = acc_addr >= FLASH_BASE && acc_addr < FLASH_BASE + FLASH_SIZE;
   assign in_sr = acc_addr >= SRAM_BASE && acc_addr < FLASH_BASE;
   assign wr_acc = psel && penable && pready && pwrite;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_end;
      !acc_busy && acc_done;
   endsequence
   sequence s_two;
      acc_busy ##1 acc_busy ##1 s_end;
   endsequence
   remap_reset_a: assert property ($rose(presetn) |-> !remap_sram)
      else $error("remap set after reset");
   remap_write_a: assert property (wr_acc && paddr == ADDR_REMAP
      |-> ##2 remap_sram == $past(pwdata[REMAP_BIT], 2))
      else $error("remap bit");
   sram_fetch_a: assert property (take && acc_kind == ACC_FETCH && in_sr
      |=> acc_cost == CYC_SRAM_FETCH ##0 acc_busy ##1 s_end)
      else $error("sram fetch cost");
   wide_fetch_a: assert property (take && acc_kind == ACC_FETCH && in_fl
      && !acc_compact |=> acc_cost == CYC_FL_FETCH32 ##0 s_two)
      else $error("wide fetch cost");
   short_fetch_a: assert property (take && acc_kind == ACC_FETCH && in_fl
      && acc_compact |=> acc_busy ##1 s_end) else $error("short fetch");
   flash_branch_a: assert property (take && acc_kind == ACC_BRANCH
      && in_fl && !acc_compact |=> acc_cost == 8'h07)
      else $error("branch cost");
   data_cost_a: assert property (take && acc_kind == ACC_DATA && in_fl
      |=> acc_cost == 8'(4 * $past(acc_words))) else $error("data cost");
   erase_cause_a: assert property (flash_op_pulse
      && flash_op_code == CMD_MASS_ERA |-> $past(wr_acc
      && paddr == ADDR_COMMAND && pwdata[7:0] == CMD_MASS_ERA))
      else $error("erase without command");
   kernel_lock_a: assert property (flash_op_pulse
      |-> flash_op_addr[15:11] != KERNEL_GROUP
      || flash_op_code == CMD_MASS_ERA) else $error("kernel written");
   kernel_start_a: assert property ($rose(presetn) && boot_mode_pin
      |-> ##[KERNEL_CYC:K1] core_start && !kernel_active
      && core_start_pc == RESET_VECTOR) else $error("kernel exit");
endmodule : flash_protect_asserts
bind flash_protect_fetch_remap flash_protect_asserts #(
   .KERNEL_CYC(KERNEL_CYC)
) u_chk (.*);

// >>> verif/flash_array_model.sv
`timescale 1ns/1ps
module flash_array_model #(
   parameter logic [23:0] SIG_VALUE = 24'h5a3c96 // Arbitrary pattern
)(
   input  wire logic        pclk,
   input  wire logic        prot_save_pulse,
   input  wire logic [31:0] prot_save_value,
   input  wire logic [15:0] flash_op_addr,
   output logic      [31:0] prot_stored,
   output logic      [15:0] flash_rdata,
   output logic      [23:0] flash_sig_value
);
   // Array cells survive reset, so no reset here
   initial prot_stored = 32'hffffffff;
   always @(posedge pclk)
   begin
      if (prot_save_pulse)
         prot_stored <= prot_save_value;
   end
   assign flash_rdata = flash_op_addr ^ 16'h5aa5;
   assign flash_sig_value = SIG_VALUE;
endmodule : flash_array_model

// >>> verif/test_flash_protect_fetch_remap.sv
`timescale 1ns/1ps
module test_flash_protect_fetch_remap
   import flash_protect_pkg::*;
;
   localparam logic [23:0] SIG = 24'h3c5a69; // Arbitrary pattern
   logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
   logic        pwrite = 1'h0, acc_req = 1'h0, acc_compact = 1'h0;
   logic [31:0] paddr = 32'h0, pwdata = 32'h0, acc_addr = 32'h0;
   logic [1:0]  acc_kind = 2'h0;
   logic [4:0]  acc_words = 5'h1;
   logic [31:0] prdata, prot_stored, prot_save_value, core_start_pc, q;
   logic [15:0] flash_rdata, flash_op_addr, flash_op_data;
   logic [23:0] flash_sig_value;
   logic [7:0]  flash_op_code, acc_cost;
   logic        pready, pslverr, flash_op_pulse, prot_save_pulse, slv;
   logic        kernel_active, core_start, remap_sram;
   logic        acc_busy, acc_done, acc_err;
   int          n_mismatch = 0, n_compared = 0;
   int          n_ops = 0, n_save = 0, cyc = 0;
   initial
   begin
      forever #50 pclk = ~pclk;
   end
   flash_protect_fetch_remap #(.ERASE_CYC(20), .SIGN_CYC(10),
      .KERNEL_CYC(4)) dut (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .boot_mode_pin(1'h1),
      .prot_stored, .flash_rdata, .flash_sig_value, .flash_op_pulse,
      .flash_op_code, .flash_op_addr, .flash_op_data, .prot_save_pulse,
      .prot_save_value, .kernel_active, .core_start, .core_start_pc,
      .remap_sram, .acc_req, .acc_kind, .acc_compact, .acc_words,
      .acc_addr, .acc_busy, .acc_done, .acc_err, .acc_cost);
   flash_array_model #(.SIG_VALUE(SIG)) model (.pclk, .prot_save_pulse,
      .prot_save_value, .flash_op_addr, .prot_stored, .flash_rdata,
      .flash_sig_value);
   task test_done();
      if (n_mismatch == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : test_done
   // Hang guard
   always @(posedge pclk)
   begin
      cyc++;
      if (flash_op_pulse === 1'h1)
         n_ops++;
      if (prot_save_pulse === 1'h1)
         n_save++;
      if (cyc == 20000)
      begin
         n_mismatch++;
         test_done();
      end
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do
         @(posedge pclk);
      while (pready !== 1'h1);
      q = prdata;
      slv = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb
   task rc(input logic [31:0] a, input logic [31:0] exp);
      apb(1'h0, a, 32'h0);
      chk(q, exp);
   endtask : rc
   task wait_idle();
      do
         apb(1'h0, ADDR_STATUS, 32'h0);
      while (q[0] !== 1'h0);
   endtask : wait_idle
   task acc(input logic [1:0] k, input logic c, input logic [4:0] w,
      input logic [31:0] a, input logic [7:0] cost, input logic e);
      int n;
      @(posedge pclk);
      acc_req <= 1'h1;
      acc_kind <= k;
      acc_compact <= c;
      acc_words <= w;
      acc_addr <= a;
      @(posedge pclk);
      acc_req <= 1'h0;
      n = 0;
      do
      begin
         @(negedge pclk);
         n++;
      end
      while (acc_done !== 1'h1);
      chk(32'(n), 32'(cost) + 32'h1);
      chk(32'(acc_cost), 32'(cost));
      chk(32'(acc_err), 32'(e));
   endtask : acc
   task rst();
      presetn <= 1'h0;
      repeat (20) @(posedge pclk);
      presetn <= 1'h1;
      @(negedge pclk);
      while (kernel_active !== 1'h0)
         @(negedge pclk);
   endtask : rst
   initial
   begin
      rst();
      chk(core_start_pc, 32'h0);
      rc(ADDR_ADDRESS, 32'h0);
      rc(ADDR_SIGN, 32'hffffff);
      rc(ADDR_PROT_P, 32'h0);
      rc(ADDR_PROT_V, 32'hffffffff);
      rc(ADDR_REMAP, 32'h0);
      apb(1'h1, ADDR_ADDRESS, 32'h1234);
      rc(ADDR_ADDRESS, 32'h1234);
      apb(1'h1, ADDR_SIGN, 32'h0);
      rc(ADDR_SIGN, 32'hffffff);
      apb(1'h1, ADDR_PROT_P, 32'h0f0f0f0f);
      rc(ADDR_PROT_P, 32'h0);
      apb(1'h0, 32'hfffff830, 32'h0);
      chk(32'(slv), 32'h1);
      // Key bit clear: no erase
      apb(1'h1, ADDR_DATA, 32'h3cff);
      apb(1'h1, ADDR_ADDRESS, 32'hffc3);
      apb(1'h1, ADDR_COMMAND, 32'h06);
      rc(ADDR_COMMAND, 32'h0);
      apb(1'h1, ADDR_MODE, 32'h08);
      apb(1'h1, ADDR_COMMAND, 32'h06);
      wait_idle();
      rc(ADDR_COMMAND, 32'h07);
      chk(32'(n_ops), 32'h1);
      chk(prot_stored, 32'hffffffff);
      apb(1'h1, ADDR_PROT_P, 32'h7fffffff);
      rc(ADDR_PROT_P, 32'h7fffffff);
      apb(1'h1, ADDR_COMMAND, 32'h0c);
      apb(1'h1, ADDR_COMMAND, 32'h0c);
      wait_idle();
      chk(32'(n_save), 32'h2);
      chk(prot_stored, 32'h7fffffff);
      apb(1'h1, ADDR_MODE, 32'h0);
      apb(1'h1, ADDR_PROT_V, 32'hfffffff7);
      apb(1'h1, ADDR_ADDRESS, 32'h1800);
      apb(1'h1, ADDR_COMMAND, 32'h02);
      apb(1'h0, ADDR_STATUS, 32'h0);
      chk(32'(q[2]), 32'h1);
      apb(1'h1, ADDR_ADDRESS, 32'hf800);
      apb(1'h1, ADDR_COMMAND, 32'h02);
      apb(1'h1, ADDR_ADDRESS, 32'h2000);
      apb(1'h1, ADDR_COMMAND, 32'h02);
      rc(ADDR_COMMAND, 32'h07);
      chk(32'(n_ops), 32'h2);
      chk(32'(flash_op_addr), 32'h2000);
      acc(ACC_FETCH, 1'h0, 5'h1, SRAM_BASE, 8'h01, 1'h0);
      acc(ACC_FETCH, 1'h0, 5'h1, FLASH_BASE, 8'h02, 1'h0);
      acc(ACC_FETCH, 1'h1, 5'h1, FLASH_BASE, 8'h01, 1'h0);
      acc(ACC_BRANCH, 1'h0, 5'h1, FLASH_BASE, 8'h07, 1'h0);
      acc(ACC_BRANCH, 1'h0, 5'h1, SRAM_BASE, 8'h03, 1'h0);
      acc(ACC_DATA, 1'h0, 5'h1, FLASH_BASE, 8'h04, 1'h0);
      acc(ACC_DATA, 1'h0, 5'h3, FLASH_BASE, 8'h0c, 1'h0);
      acc(ACC_DATA, 1'h0, 5'h2, SRAM_BASE, 8'h02, 1'h0);
      apb(1'h1, ADDR_PROT_V, 32'h7fffffff);
      acc(ACC_DATA, 1'h0, 5'h1, FLASH_BASE, 8'h04, 1'h1);
      acc(ACC_FETCH, 1'h0, 5'h1, 32'h0, 8'h02, 1'h0);
      // Remap is toggled while running from upper flash
      acc(ACC_FETCH, 1'h0, 5'h1, 32'h80100, 8'h02, 1'h0);
      apb(1'h1, ADDR_REMAP, 32'h1);
      acc(ACC_FETCH, 1'h0, 5'h1, 32'h0, 8'h01, 1'h0);
      apb(1'h1, ADDR_REMAP, 32'h0);
      acc(ACC_FETCH, 1'h0, 5'h1, 32'h0, 8'h02, 1'h0);
      apb(1'h1, ADDR_REMAP, 32'h1);
      apb(1'h1, ADDR_COMMAND, 32'h0b);
      wait_idle();
      rc(ADDR_SIGN, {8'h0, SIG});
      rst();
      chk(32'(remap_sram), 32'h0);
      rc(ADDR_PROT_V, 32'hffffffff);
      acc(ACC_DATA, 1'h0, 5'h1, FLASH_BASE, 8'h04, 1'h1);
      test_done();
   end
endmodule : test_flash_protect_fetch_remap
